// file: verilog/gsi_pkg.sv
// Package for the gripper state and indicator block
package gsi_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int FAIL_RED_S = 5;
	localparam int FAIL_RED_CYC = FAIL_RED_S * CLK_HZ;
	localparam int SLOW_MS = 1000;
	localparam int FAST_MS = 200;
	localparam int PULSE_MS = 150;
	localparam int SWF_SHORT_MS = 150;
	localparam int SWF_PAUSE_MS = 1200;
	localparam int RESTART_MS = 2000;
	localparam int SLOW_CYC = SLOW_MS * (CLK_HZ / 1000);
	localparam int FAST_CYC = FAST_MS * (CLK_HZ / 1000);
	localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
	localparam int SWF_SHORT_CYC = SWF_SHORT_MS * (CLK_HZ / 1000);
	localparam int SWF_PAUSE_CYC = SWF_PAUSE_MS * (CLK_HZ / 1000);
	localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
	localparam logic [7:0] CMD_STATUS = 8'h40;
	localparam logic [7:0] CMD_ACK = 8'h24;
	localparam logic [7:0] CMD_GRIP = 8'h25;
	localparam logic [7:0] CMD_RELEASE = 8'h26;
	localparam logic [7:0] CMD_PREPOS = 8'h21;
	localparam logic [7:0] CMD_STOP = 8'h22;
	localparam logic [2:0] COL_OFF = 3'h0;
	localparam logic [2:0] COL_RED = 3'h1;
	localparam logic [2:0] COL_GREEN = 3'h2;
	localparam logic [2:0] COL_BLUE = 3'h4;
	localparam logic [2:0] COL_YELLOW = 3'h3;
	localparam logic [2:0] COL_WHITE = 3'h7;
	typedef enum logic [2:0] {
		GS_IDLE = 3'h0,
		GS_CLOSING = 3'h1,
		GS_CLAMPING = 3'h3,
		GS_DROPPED = 3'h2,
		GS_EMPTY_CLOSE = 3'h6,
		GS_OPENING_RELEASE = 3'h7,
		GS_PRE_MOVING = 3'h5,
		GS_ERROR = 3'h4
	} gsi_grip_e;
	typedef enum logic [2:0] {
		BS_LOAD = 3'h0,
		BS_FAIL = 3'h1,
		BS_START = 3'h3,
		BS_RUN = 3'h2,
		BS_SWFAULT = 3'h6
	} gsi_boot_e;
	typedef struct packed {
		logic load_done;
		logic load_fail;
		logic start_done;
		logic sw_fault;
	} gsi_boot_s;
	typedef struct packed {
		logic part_seen;
		logic force_lost;
		logic at_target;
		logic cmd_fail;
		logic fault_needs_ack;
		logic critical;
	} gsi_motion_s;
	typedef struct packed {
		logic homed;
		logic halt_pending;
		logic critical;
		logic warning;
		logic script_run;
		logic busy;
		logic [2:0] grip;
	} gsi_status_s;
endpackage : gsi_pkg

// file: verilog/gsi_top.sv
// Boot supervisor, gripping-state tracker and lamp driver
// Overview of operation
// - Load failure shows red five seconds, then reloads, retrying until success.
// - Ready and waiting: slow white pulsing.
// - Initialising or executing a command: fast white pulsing.
// - Script running: fast green pulsing.
// - Warning limits reached: fast yellow pulsing.
// - Software fault halts, flashes red twice then pause, restarts later.
// - Activity lamps lit while interface active, flashing with traffic.
// - Grip state is one of eight values; idle means nothing in progress.
// - Closing: fingers move to part, part detection active.
// - Clamping: part held with set force, hold monitor active.
// - Dropped entered when gripping force can no longer be kept.
// - Empty close entered when fingers close with no part found.
// - Report opening_release while opening, pre-moving while pre-positioning.
// - Command failure enters error; ack-needing errors set halt flag.
// - Grip state carries no homing; homed flag is separate.
// - Stop outside error aborts and returns to idle at once.
// - Status word returned on request with command 40h.
// - Acknowledge 24h clears halt, only once the fault has gone.
`timescale 1ns/1ps
module gsi_top
	import gsi_pkg::*;
#(
	parameter int FAIL_CYC = FAIL_RED_CYC,
	parameter int SLOW_P = SLOW_CYC,
	parameter int FAST_P = FAST_CYC,
	// Pulse and fault-code lengths scale with the fast blink by default
	parameter int PULSE_P = int'(longint'(FAST_P) * PULSE_MS / FAST_MS),
	parameter int SHORT_P = int'(longint'(FAST_P) * SWF_SHORT_MS / FAST_MS),
	parameter int PAUSE_P = int'(longint'(FAST_P) * SWF_PAUSE_MS / FAST_MS),
	parameter int RESTART_P = RESTART_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Boot events from the loader
	input wire gsi_boot_s boot_in,
	// Host command strobe
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_rx_err,
	// Motion and monitor feedback
	input wire gsi_motion_s motion_in,
	input wire logic homed_flag,
	input wire logic warning_in,
	input wire logic script_run,
	// Interface activity
	input wire logic card_active,
	input wire logic card_traffic,
	input wire logic comm_active,
	input wire logic comm_traffic,
	// Status answer and controls
	output gsi_status_s status_word,
	output logic status_valid,
	output logic motion_enable,
	output logic sw_restart,
	// Lamps
	output logic [2:0] lamp_rgb,
	output logic card_lamp,
	output logic comm_lamp
);
	// Pin-level activity inputs pass two flops
	logic [3:0] act_s1_r;
	logic [3:0] act_s2_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			act_s1_r <= 4'h0;
			act_s2_r <= 4'h0;
		end else begin
			act_s1_r <= {card_active, card_traffic, comm_active, comm_traffic};
			act_s2_r <= act_s1_r;
		end
	end

	gsi_boot_e boot_r;
	gsi_boot_e boot_nxt;
	gsi_grip_e grip_r;
	gsi_grip_e grip_nxt;
	logic [31:0] tmr_r;
	logic halt_pending_flag_r;
	logic [31:0] slow_r;
	logic [31:0] fast_r;
	logic slow_ph_r;
	logic fast_ph_r;
	logic [31:0] pulse_r;
	logic [2:0] pulse_col_r;
	logic [2:0] swf_step_r;
	logic [31:0] swf_tmr_r;

	// Strobes before the software runs are dropped without a pulse
	wire running = (boot_r == BS_RUN);
	wire cmd_take = cmd_valid && running;
	// A garbled command only earns a red pulse; it is never acted on
	wire cmd_ok = cmd_take && !cmd_rx_err;
	wire is_stop = cmd_ok && (cmd_code == CMD_STOP);
	wire is_ack = cmd_ok && (cmd_code == CMD_ACK);
	wire is_grip = cmd_ok && (cmd_code == CMD_GRIP);
	wire is_rel = cmd_ok && (cmd_code == CMD_RELEASE);
	wire is_pre = cmd_ok && (cmd_code == CMD_PREPOS);
	wire motion_cmd = is_grip || is_rel || is_pre;
	wire fault_now = motion_in.critical || motion_in.fault_needs_ack;
	wire ack_ok = is_ack && !fault_now;
	wire motion_ok = motion_cmd && !halt_pending_flag_r && (grip_r != GS_ERROR);
	wire cmd_bad = cmd_take && (cmd_rx_err || (motion_cmd && !motion_ok)
		|| (is_ack && fault_now));
	wire tmr_done = (tmr_r == 32'h0);

	// Boot supervisor
	always_comb begin
		boot_nxt = boot_r;
		case (boot_r)
			BS_LOAD: begin
				if (boot_in.load_fail) begin
					boot_nxt = BS_FAIL;
				end else if (boot_in.load_done) begin
					boot_nxt = BS_START;
				end
			end
			BS_FAIL: begin
				if (tmr_done) begin
					boot_nxt = BS_LOAD;
				end
			end
			BS_START: begin
				if (boot_in.start_done) begin
					boot_nxt = BS_RUN;
				end
			end
			BS_RUN: begin
				if (boot_in.sw_fault) begin
					boot_nxt = BS_SWFAULT;
				end
			end
			BS_SWFAULT: begin
				if (tmr_done) begin
					boot_nxt = BS_LOAD;
				end
			end
			default: boot_nxt = BS_LOAD;
		endcase
	end

	wire enter_fail = (boot_r == BS_LOAD) && boot_in.load_fail;
	wire enter_swf = (boot_r == BS_RUN) && boot_in.sw_fault;
	// One down-counter serves both timed boot states; they never overlap
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			boot_r <= BS_LOAD;
			tmr_r <= 32'h0;
		end else begin
			boot_r <= boot_nxt;
			if (enter_fail) begin
				tmr_r <= 32'(FAIL_CYC - 1);
			end else if (enter_swf) begin
				tmr_r <= 32'(RESTART_P - 1);
			end else if (!tmr_done) begin
				tmr_r <= tmr_r - 32'h1;
			end
		end
	end

	// Gripping-process state; homing is never folded in
	always_comb begin
		grip_nxt = grip_r;
		if (!running) begin
			grip_nxt = GS_IDLE;
		end else if (grip_r == GS_ERROR) begin
			if (ack_ok) begin
				grip_nxt = GS_IDLE;
			end
		end else if (is_stop) begin
			grip_nxt = GS_IDLE;
		end else if (motion_in.cmd_fail || motion_in.critical) begin
			grip_nxt = GS_ERROR;
		end else if (motion_ok) begin
			if (is_grip) begin
				grip_nxt = GS_CLOSING;
			end else if (is_rel) begin
				grip_nxt = GS_OPENING_RELEASE;
			end else begin
				grip_nxt = GS_PRE_MOVING;
			end
		end else begin
			case (grip_r)
				GS_CLOSING: begin
					if (motion_in.part_seen) begin
						grip_nxt = GS_CLAMPING;
					end else if (motion_in.at_target) begin
						grip_nxt = GS_EMPTY_CLOSE;
					end
				end
				GS_CLAMPING: begin
					if (motion_in.force_lost) begin
						grip_nxt = GS_DROPPED;
					end
				end
				GS_OPENING_RELEASE, GS_PRE_MOVING: begin
					if (motion_in.at_target) begin
						grip_nxt = GS_IDLE;
					end
				end
				default: grip_nxt = grip_r;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			grip_r <= GS_IDLE;
			halt_pending_flag_r <= 1'b0;
		end else begin
			grip_r <= grip_nxt;
			// Set wins over a same-cycle acknowledge so a live fault is kept
			if (running && (motion_in.fault_needs_ack || motion_in.critical)) begin
				halt_pending_flag_r <= 1'b1;
			end else if (ack_ok) begin
				halt_pending_flag_r <= 1'b0;
			end
		end
	end

	// Status answer and controls
	// Fields are refreshed every cycle; a read returns last cycle's view
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_word <= '0;
			status_valid <= 1'b0;
			motion_enable <= 1'b0;
			sw_restart <= 1'b0;
		end else begin
			status_valid <= cmd_ok && (cmd_code == CMD_STATUS);
			status_word.homed <= homed_flag;
			status_word.halt_pending <= halt_pending_flag_r;
			status_word.critical <= motion_in.critical;
			status_word.warning <= warning_in;
			status_word.script_run <= script_run;
			status_word.busy <= (grip_r == GS_CLOSING) || (grip_r == GS_OPENING_RELEASE)
				|| (grip_r == GS_PRE_MOVING);
			status_word.grip <= grip_r;
			motion_enable <= running && !halt_pending_flag_r && (grip_r != GS_ERROR);
			sw_restart <= (boot_r == BS_SWFAULT) && tmr_done;
		end
	end

	// Blink timebases
	// Free-running, so a pattern may start part way through a period
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slow_r <= 32'h0;
			fast_r <= 32'h0;
			slow_ph_r <= 1'b0;
			fast_ph_r <= 1'b0;
		end else begin
			slow_r <= (slow_r == 32'(SLOW_P / 2 - 1)) ? 32'h0 : slow_r + 32'h1;
			fast_r <= (fast_r == 32'(FAST_P / 2 - 1)) ? 32'h0 : fast_r + 32'h1;
			if (slow_r == 32'(SLOW_P / 2 - 1)) begin
				slow_ph_r <= ~slow_ph_r;
			end
			if (fast_r == 32'(FAST_P / 2 - 1)) begin
				fast_ph_r <= ~fast_ph_r;
			end
		end
	end

	// Single command pulse; a new event restarts it
	// Red wins when a failure and an accepted strobe coincide
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse_r <= 32'h0;
			pulse_col_r <= COL_OFF;
		end else if (cmd_bad || (running && motion_in.cmd_fail)) begin
			pulse_r <= 32'(PULSE_P);
			pulse_col_r <= COL_RED;
		end else if (cmd_take) begin
			pulse_r <= 32'(PULSE_P);
			pulse_col_r <= COL_GREEN;
		end else if (pulse_r != 32'h0) begin
			pulse_r <= pulse_r - 32'h1;
		end
	end

	// Software fault code: on, off, on, long pause
	// Pause dwarfs the flashes so the pair reads as one code
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			swf_step_r <= 3'h0;
			swf_tmr_r <= 32'h0;
		end else if (boot_r != BS_SWFAULT) begin
			swf_step_r <= 3'h0;
			swf_tmr_r <= 32'(SHORT_P - 1);
		end else if (swf_tmr_r != 32'h0) begin
			swf_tmr_r <= swf_tmr_r - 32'h1;
		end else begin
			swf_step_r <= (swf_step_r == 3'h3) ? 3'h0 : swf_step_r + 3'h1;
			swf_tmr_r <= (swf_step_r == 3'h2) ? 32'(PAUSE_P - 1) : 32'(SHORT_P - 1);
		end
	end

	wire swf_on = !swf_step_r[0];
	logic [2:0] bg_col;
	always_comb begin
		bg_col = COL_OFF;
		case (boot_r)
			BS_LOAD: bg_col = COL_BLUE;
			BS_FAIL: bg_col = COL_RED;
			BS_START: bg_col = fast_ph_r ? COL_BLUE : COL_OFF;
			BS_SWFAULT: bg_col = swf_on ? COL_RED : COL_OFF;
			BS_RUN: begin
				// Faults outrank the other background patterns; a command pulse still covers them
				if (halt_pending_flag_r || motion_in.critical) begin
					bg_col = fast_ph_r ? COL_RED : COL_OFF;
				end else if (warning_in) begin
					bg_col = fast_ph_r ? COL_YELLOW : COL_OFF;
				end else if (script_run) begin
					bg_col = fast_ph_r ? COL_GREEN : COL_OFF;
				end else if (status_word.busy || !boot_in.start_done) begin
					bg_col = fast_ph_r ? COL_WHITE : COL_OFF;
				end else begin
					bg_col = slow_ph_r ? COL_WHITE : COL_OFF;
				end
			end
			default: bg_col = COL_OFF;
		endcase
	end

	wire pulse_on = running && (pulse_r != 32'h0);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lamp_rgb <= COL_OFF;
			card_lamp <= 1'b0;
			comm_lamp <= 1'b0;
		end else begin
			lamp_rgb <= pulse_on ? pulse_col_r : bg_col;
			// Traffic blanks the lit lamp, so a busy link reads as flicker
			card_lamp <= act_s2_r[3] && !act_s2_r[2];
			comm_lamp <= act_s2_r[1] && !act_s2_r[0];
		end
	end
endmodule : gsi_top

// file: tb/gsi_host_model.sv
// Host controller model issuing one-cycle command strobes
`timescale 1ns/1ps
module gsi_host_model (
	// Command strobe
	input wire logic clk,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic cmd_rx_err
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_rx_err = 1'b0;
	end
	// Code inverted after the strobe so a held code never looks valid
	task send(input logic [7:0] code);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = code;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = ~code;
	endtask : send
	// Same strobe flagged as received with an error
	task send_bad(input logic [7:0] code);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_rx_err = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = ~code;
		cmd_rx_err = 1'b0;
	endtask : send_bad
endmodule : gsi_host_model

// file: tb/gsi_properties.sv
// Concurrent checks on the gripper block ports
`timescale 1ns/1ps
module gsi_properties
	import gsi_pkg::*;
(
	// Clock, reset and inputs
	input wire logic clk,
	input wire logic nrst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire gsi_motion_s motion_in,
	input wire logic card_active,
	input wire logic card_traffic,
	// Results
	input wire gsi_status_s status_word,
	input wire logic status_valid,
	input wire logic motion_enable,
	input wire logic [2:0] lamp_rgb,
	input wire logic card_lamp
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	wire is_ack = cmd_valid && cmd_code == CMD_ACK;
	wire is_stop = cmd_valid && cmd_code == CMD_STOP;
	wire in_err = status_word.grip == GS_ERROR;
	sequence s_halted;
		status_word.halt_pending [*2];
	endsequence
	// Margin for the two-flop synchroniser
	sequence s_lit;
		(card_active && !card_traffic) [*5];
	endsequence
	chk_status_cause: assert property (status_valid |-> $past(cmd_valid && cmd_code == CMD_STATUS))
		else $error("status answer without request");
	chk_reset_blue: assert property ($rose(nrst) |=> lamp_rgb == COL_BLUE)
		else $error("lamp not blue after reset");
	chk_stop_idle: assert property (is_stop && !in_err |-> ##2 status_word.grip == GS_IDLE)
		else $error("stop did not reach idle");
	chk_error_stop: assert property (is_stop && in_err |-> ##2 in_err)
		else $error("stop left error state");
	chk_ack_refused: assert property (is_ack && (motion_in.critical || motion_in.fault_needs_ack) |-> ##2 status_word.halt_pending)
		else $error("ack taken with fault present");
	chk_ack_cause: assert property ($fell(status_word.halt_pending) |-> $past(is_ack, 2))
		else $error("halt cleared without ack");
	chk_halt_locks: assert property (s_halted |-> !motion_enable)
		else $error("motion allowed while halted");
	chk_grip_refused: assert property (cmd_valid && cmd_code == CMD_GRIP && status_word.halt_pending |-> ##2 status_word.grip != GS_CLOSING)
		else $error("grip taken while halted");
	chk_card_lit: assert property (s_lit |-> card_lamp)
		else $error("card lamp dark while active");
endmodule : gsi_properties

// file: tb/gsi_top_test.sv
// Self-checking bench for the gripper state and lamp block
`timescale 1ns/1ps
module gsi_top_test;
	import gsi_pkg::*;
	typedef struct packed {
		logic [7:0] code;
		gsi_motion_s m;
		logic [2:0] g;
	} gsi_row_s;
	logic clk, nrst, cmd_valid, cmd_rx_err, st_v, me, swr, cl, ml;
	logic homed, warn, scr, ca, ct, ma, mt;
	logic [7:0] cmd_code;
	logic [2:0] lamp;
	gsi_boot_s boot;
	gsi_motion_s mot;
	gsi_status_s sw;
	gsi_row_s rows [9];
	int num_errors = 0;
	int n_tests = 0;
	gsi_host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_rx_err(cmd_rx_err));
	gsi_top #(.FAIL_CYC(20), .SLOW_P(16), .FAST_P(8),
		.RESTART_P(60)) u_dut (.clk(clk), .nrst(nrst), .boot_in(boot),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_rx_err(cmd_rx_err), .motion_in(mot),
		.homed_flag(homed), .warning_in(warn), .script_run(scr), .card_active(ca),
		.card_traffic(ct), .comm_active(ma), .comm_traffic(mt), .status_word(sw),
		.status_valid(st_v), .motion_enable(me), .sw_restart(swr), .lamp_rgb(lamp),
		.card_lamp(cl), .comm_lamp(ml));
	task cmp1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t bit %b exp %b", $time, got, exp);
		end
	endtask : cmp1
	task cmp3(input logic [2:0] got, input logic [2:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t value %h exp %h", $time, got, exp);
		end
	endtask : cmp3
	task wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n
	// A flashing pattern must show both the colour and dark
	task see_col(input logic [2:0] c);
		logic hit_c, hit_o;
		hit_c = 1'b0;
		hit_o = 1'b0;
		repeat (40) begin
			@(negedge clk);
			hit_c |= lamp === c;
			hit_o |= lamp === COL_OFF;
		end
		cmp1(hit_c & hit_o, 1'b1);
	endtask : see_col
	task end_sim;
		$display("errors %0d tests %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#50000;
		num_errors++;
		end_sim();
	end
	initial begin
		nrst = 1'b0;
		boot = '0;
		mot = '0;
		homed = 1'b0;
		warn = 1'b0;
		scr = 1'b0;
		ca = 1'b0;
		ct = 1'b0;
		ma = 1'b0;
		mt = 1'b0;
		rows = '{'{CMD_GRIP, 6'h00, GS_CLOSING}, '{8'h00, 6'h20, GS_CLAMPING},
			'{8'h00, 6'h10, GS_DROPPED}, '{CMD_STOP, 6'h00, GS_IDLE},
			'{CMD_GRIP, 6'h00, GS_CLOSING}, '{8'h00, 6'h08, GS_EMPTY_CLOSE},
			'{CMD_RELEASE, 6'h00, GS_OPENING_RELEASE}, '{CMD_PREPOS, 6'h00, GS_PRE_MOVING},
			'{CMD_STOP, 6'h00, GS_IDLE}};
		wait_n(5);
		nrst = 1'b1;
		wait_n(2);
		cmp3(lamp, COL_BLUE);
		boot = 4'h4;
		wait_n(1);
		boot = '0;
		wait_n(2);
		cmp3(lamp, COL_RED);
		wait_n(14);
		cmp3(lamp, COL_RED);
		wait_n(8);
		cmp3(lamp, COL_BLUE);
		boot = 4'h8;
		wait_n(1);
		boot = '0;
		see_col(COL_BLUE);
		boot = 4'h2;
		homed = 1'b1;
		see_col(COL_WHITE);
		cmp1(sw.homed, 1'b1);
		cmp3(sw.grip, GS_IDLE);
		u_host.send(CMD_STATUS);
		cmp1(st_v, 1'b1);
		wait_n(1);
		cmp1(st_v, 1'b0);
		cmp3(lamp, COL_GREEN);
		wait_n(8);
		cmp1(lamp == COL_WHITE || lamp == COL_OFF, 1'b1);
		for (int i = 0; i < 9; i++) begin
			if (rows[i].code !== 8'h00) u_host.send(rows[i].code);
			else begin
				@(negedge clk);
				mot = rows[i].m;
				@(negedge clk);
				mot = '0;
			end
			wait_n(3);
			cmp3(sw.grip, rows[i].g);
		end
		u_host.send(CMD_GRIP);
		see_col(COL_WHITE);
		cmp1(sw.busy, 1'b1);
		mot = 6'h07;
		wait_n(3);
		cmp3(sw.grip, GS_ERROR);
		cmp1(sw.halt_pending, 1'b1);
		cmp1(me, 1'b0);
		cmp1(sw.critical, 1'b1);
		u_host.send(CMD_STOP);
		u_host.send(CMD_GRIP);
		wait_n(1);
		cmp3(lamp, COL_RED);
		u_host.send(CMD_ACK);
		wait_n(3);
		cmp3(sw.grip, GS_ERROR);
		cmp1(sw.halt_pending, 1'b1);
		mot = '0;
		wait_n(2);
		u_host.send(CMD_ACK);
		wait_n(3);
		cmp3(sw.grip, GS_IDLE);
		cmp1(sw.halt_pending, 1'b0);
		cmp1(me, 1'b1);
		u_host.send_bad(CMD_GRIP);
		wait_n(1);
		cmp3(lamp, COL_RED);
		wait_n(2);
		cmp3(sw.grip, GS_IDLE);
		warn = 1'b1;
		see_col(COL_YELLOW);
		cmp1(sw.warning, 1'b1);
		warn = 1'b0;
		scr = 1'b1;
		see_col(COL_GREEN);
		cmp1(sw.script_run, 1'b1);
		scr = 1'b0;
		ca = 1'b1;
		ma = 1'b1;
		ct = 1'b1;
		wait_n(6);
		cmp1(cl, 1'b0);
		cmp1(ml, 1'b1);
		ct = 1'b0;
		mt = 1'b1;
		wait_n(6);
		cmp1(cl, 1'b1);
		cmp1(ml, 1'b0);
		boot = 4'h3;
		wait_n(1);
		boot = 4'h2;
		see_col(COL_RED);
		for (int i = 0; i < 80 && swr !== 1'b1; i++) @(negedge clk);
		cmp1(swr, 1'b1);
		if (swr !== 1'b1) end_sim();
		wait_n(2);
		cmp3(lamp, COL_BLUE);
		end_sim();
	end
endmodule : gsi_top_test
bind gsi_top gsi_properties u_chk (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
	.cmd_code(cmd_code), .motion_in(motion_in), .card_active(card_active),
	.card_traffic(card_traffic), .status_word(status_word), .status_valid(status_valid),
	.motion_enable(motion_enable), .lamp_rgb(lamp_rgb), .card_lamp(card_lamp));
